// ### hdl/spl_stack_guard.sv
// Stack pointer, push/pop sequencing and stack bound trap logic.
// Assumes the core sends single-cycle requests on clk and waits on ready.
//
// Contract
// - Working register also serves as stack pointer
// - Pointer always addresses the next free word
// - Stack grows toward higher addresses
// - Pop pre-decrements, push post-increments
// - Call push zero-extends program counter top byte
// - Exception push carries status low byte upward
// - Limit register keeps its content through reset
// - Limit bit zero always reads zero
// - Every stack pointer address checked against limit
// - Push at limit passes; next push traps
// - Address below fixed bound raises underflow trap
`timescale 1ns/1ps
module spl_stack_guard
  import spl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire spl_pkg::spl_stack_req_t stack_req,
  input wire spl_pkg::spl_reg_wr_t reg_wr,
  input wire spl_pkg::spl_ea_req_t ea_req,
  output logic ready,
  output spl_pkg::spl_mem_t mem,
  output spl_pkg::spl_trap_t trap,
  output logic [15:0] stack_pointer_register,
  output logic [15:0] stack_limit_register
);
  import spl_pkg::*;

  spl_core_state_t state_reg;
  spl_core_state_t state_next;
  logic [15:0] check_addr;
  logic check_borrow;
  logic over;
  logic under;
  logic idle;
  logic push_go;
  logic pop_go;
  logic ea_go;

  // Word step of the pointer, used by push and pop
  function automatic logic [15:0] sp_step(input logic [15:0] sp, input logic up);
    sp_step = up ? 16'(sp + SPL_WORD_STEP) : 16'(sp - SPL_WORD_STEP);
  endfunction

  // Stack pointer and limit are word aligned
  function automatic logic [15:0] word_align(input logic [15:0] v);
    word_align = {v[15:1], 1'b0};
  endfunction

  // Core may only start a request while idle; the second PC word stalls it
  always_comb begin
    idle = (state_reg.fsm == SPL_ST_IDLE);
    ready = idle;
    push_go = idle && stack_req.push;
    pop_go = idle && !stack_req.push && stack_req.pop;
    ea_go = idle && !stack_req.push && !stack_req.pop && ea_req.valid;
  end

  // One comparator sees whichever address the stack pointer forms this cycle
  always_comb begin
    check_borrow = 1'b0;
    if (!idle || push_go) begin
      check_addr = state_reg.stack_pointer_register;
    end else if (pop_go) begin
      check_addr = sp_step(state_reg.stack_pointer_register, 1'b0);
      check_borrow = (state_reg.stack_pointer_register < SPL_WORD_STEP);
    end else begin
      check_addr = ea_req.addr;
    end
  end

  spl_ea_check u_check (
    .effective_address(check_addr),
    .limit(state_reg.stack_limit_register),
    .borrow(check_borrow),
    .over(over),
    .under(under)
  );

  // Next-state logic for the whole block
  always_comb begin
    state_next = state_reg;
    state_next.mem.we = 1'b0;
    state_next.mem.re = 1'b0;
    state_next.trap = '0;
    // Limit is written here only, never by reset; a write during reset still lands
    if (reg_wr.lim_we) begin
      state_next.stack_limit_register = word_align(reg_wr.lim_wdata);
    end
    if (!rstn) begin
      state_next.fsm = SPL_ST_IDLE;
      state_next.stack_pointer_register = SPL_SP_RESET;
      state_next.pc_hi_word = '0;
      state_next.mem = '0;
      state_next.trap = '0;
      // Limit left alone so reset cannot give it a value
    end else begin
      unique case (state_reg.fsm)
        SPL_ST_IDLE: begin
          if (push_go || pop_go || ea_go) begin
            // Aborted access on trap: neither memory nor pointer moves
            if (over || under) begin
              state_next.trap.trap = 1'b1;
              state_next.trap.over = over;
              state_next.trap.under = under;
              state_next.trap.addr = check_addr;
            end else if (push_go) begin
              // Write at the free word, then step up
              state_next.mem.we = 1'b1;
              state_next.mem.addr = state_reg.stack_pointer_register;
              state_next.stack_pointer_register =
                sp_step(state_reg.stack_pointer_register, 1'b1);
              if (stack_req.kind == SPL_PUSH_DATA) begin
                state_next.mem.wdata = stack_req.data;
              end else begin
                state_next.mem.wdata = stack_req.pc[SPL_PC_LO_W-1:0];
                state_next.fsm = SPL_ST_PC_HI;
                if (stack_req.kind == SPL_PUSH_EXC) begin
                  state_next.pc_hi_word = {stack_req.status_low_byte, 1'b0,
                    stack_req.pc[SPL_PC_HI_MSB:SPL_PC_LO_W]};
                end else begin
                  state_next.pc_hi_word = {SPL_PC_HI_EXT, 1'b0,
                    stack_req.pc[SPL_PC_HI_MSB:SPL_PC_LO_W]};
                end
              end
            end else if (pop_go) begin
              // Step down first, then read the last written word
              state_next.mem.re = 1'b1;
              state_next.mem.addr = check_addr;
              state_next.stack_pointer_register = check_addr;
            end
          end else if (reg_wr.sp_we) begin
            state_next.stack_pointer_register = word_align(reg_wr.sp_wdata);
          end
        end
        SPL_ST_PC_HI: begin
          state_next.fsm = SPL_ST_IDLE;
          if (over || under) begin
            state_next.trap.trap = 1'b1;
            state_next.trap.over = over;
            state_next.trap.under = under;
            state_next.trap.addr = check_addr;
          end else begin
            state_next.mem.we = 1'b1;
            state_next.mem.addr = state_reg.stack_pointer_register;
            state_next.mem.wdata = state_reg.pc_hi_word;
            state_next.stack_pointer_register =
              sp_step(state_reg.stack_pointer_register, 1'b1);
          end
        end
        default: begin
          state_next.fsm = SPL_ST_IDLE;
        end
      endcase
    end
  end

  // Single state register; reset is applied in the next-state logic
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  // Outputs straight from flops
  always_comb begin
    mem = state_reg.mem;
    trap = state_reg.trap;
    stack_pointer_register = state_reg.stack_pointer_register;
    stack_limit_register = state_reg.stack_limit_register;
  end

  // Push writes the free word, then steps the pointer up
  a_push_post_inc: assert property (@(posedge clk) disable iff (!rstn)
    (push_go && !over && !under) |=> mem.we
      && mem.addr == $past(state_reg.stack_pointer_register)
      && stack_pointer_register == 16'($past(state_reg.stack_pointer_register) + SPL_WORD_STEP))
    else $error("push did not write then step the pointer up");

  // Pop steps the pointer down, then reads there
  a_pop_pre_dec: assert property (@(posedge clk) disable iff (!rstn)
    (pop_go && !over && !under) |=> mem.re
      && mem.addr == 16'($past(state_reg.stack_pointer_register) - SPL_WORD_STEP)
      && stack_pointer_register == mem.addr)
    else $error("pop did not step the pointer down before reading");

  a_call_hi_zero: assert property (@(posedge clk) disable iff (!rstn)
    (push_go && stack_req.kind == SPL_PUSH_CALL && !over && !under)
      |=> state_reg.fsm == SPL_ST_PC_HI && state_reg.pc_hi_word[15:7] == 9'h000)
    else $error("call push upper word not zero-extended");

  // Status low byte travels in the upper word of an exception push
  a_exc_status_byte: assert property (@(posedge clk) disable iff (!rstn)
    (push_go && stack_req.kind == SPL_PUSH_EXC && !over && !under)
      |=> state_reg.pc_hi_word[15:8] == $past(stack_req.status_low_byte)
      ##1 ((mem.we && mem.wdata[15:8] == $past(stack_req.status_low_byte, 2))
        || trap.trap))
    else $error("exception push lost the status low byte");

  a_limit_aligned: assert property (@(posedge clk) disable iff (!rstn)
    reg_wr.lim_we |=> stack_limit_register[0] == 1'b0
      && stack_limit_register[15:1] == $past(reg_wr.lim_wdata[15:1]))
    else $error("limit write not word aligned");

  // Reset alone never moves the limit
  a_limit_kept_reset: assert property (@(posedge clk)
    (!rstn && !reg_wr.lim_we) |=> stack_limit_register == $past(stack_limit_register))
    else $error("reset changed the stack limit");

  // Pointer equal to the limit may still push once
  a_push_at_limit: assert property (@(posedge clk) disable iff (!rstn)
    (push_go && state_reg.stack_pointer_register == state_reg.stack_limit_register
      && state_reg.stack_pointer_register >= SPL_SFR_BOUND)
      |=> mem.we && !trap.trap)
    else $error("push at the limit was trapped");

  a_push_over_limit: assert property (@(posedge clk) disable iff (!rstn)
    (push_go && state_reg.stack_pointer_register > state_reg.stack_limit_register)
      |=> trap.trap && trap.over && !mem.we && $stable(stack_pointer_register))
    else $error("push beyond the limit did not trap");

  // Pointer address beyond the limit traps as overflow
  a_ea_checked: assert property (@(posedge clk) disable iff (!rstn)
    (ea_go && ea_req.addr > state_reg.stack_limit_register)
      |=> trap.trap && trap.over && trap.addr == $past(ea_req.addr))
    else $error("stack address beyond the limit not trapped");

  // Pop that would land below the bound traps
  a_underflow_trap: assert property (@(posedge clk) disable iff (!rstn)
    (pop_go && state_reg.stack_pointer_register < 16'(SPL_SFR_BOUND + SPL_WORD_STEP))
      |=> trap.trap && trap.under && !mem.re)
    else $error("pop below the bound did not trap");

  // Plain register write lands only when no stack access claims the cycle
  a_sp_as_working: assert property (@(posedge clk) disable iff (!rstn)
    (idle && reg_wr.sp_we && !stack_req.push && !stack_req.pop && !ea_req.valid)
      |=> stack_pointer_register == {$past(reg_wr.sp_wdata[15:1]), 1'b0})
    else $error("working register write lost");

  // Call upper word reaches memory zero-extended
  a_call_hi_word: assert property (@(posedge clk) disable iff (!rstn)
    (push_go && stack_req.kind == SPL_PUSH_CALL && !over && !under)
      |=> ##1 (trap.trap || (mem.we && mem.wdata == {SPL_PC_HI_EXT, 1'b0,
        $past(stack_req.pc[SPL_PC_HI_MSB:SPL_PC_LO_W], 2)})))
    else $error("call push upper word wrong on the bus");

  // Exception upper word keeps the counter bits below the status byte
  a_exc_low_bits: assert property (@(posedge clk) disable iff (!rstn)
    (push_go && stack_req.kind == SPL_PUSH_EXC && !over && !under)
      |=> ##1 (trap.trap || (mem.we && mem.wdata[7:0] == {1'b0,
        $past(stack_req.pc[SPL_PC_HI_MSB:SPL_PC_LO_W], 2)})))
    else $error("exception push upper word low bits wrong");

  // Two-word push holds ready low for exactly the second word
  a_pc_hi_stall: assert property (@(posedge clk) disable iff (!rstn)
    (push_go && stack_req.kind != SPL_PUSH_DATA && !over && !under)
      |=> !ready ##1 ready)
    else $error("two-word push did not stall for one cycle");

  // Second word written at the limit still passes
  a_hi_at_limit: assert property (@(posedge clk) disable iff (!rstn)
    (!idle && state_reg.stack_pointer_register == state_reg.stack_limit_register
      && state_reg.stack_pointer_register >= SPL_SFR_BOUND)
      |=> mem.we && !trap.trap)
    else $error("second word at the limit was trapped");

  // Second word beyond the limit traps; pointer stays after the first word
  a_hi_over_limit: assert property (@(posedge clk) disable iff (!rstn)
    (!idle && state_reg.stack_pointer_register > state_reg.stack_limit_register)
      |=> trap.trap && trap.over && !mem.we && $stable(stack_pointer_register))
    else $error("second word beyond the limit did not trap");

  // Pointer address below the bound traps as underflow
  a_ea_underflow: assert property (@(posedge clk) disable iff (!rstn)
    (ea_go && ea_req.addr < SPL_SFR_BOUND)
      |=> trap.trap && trap.under && trap.addr == $past(ea_req.addr))
    else $error("stack address below the bound not trapped");

  // Address inside the window passes without side effects
  a_ea_in_range: assert property (@(posedge clk) disable iff (!rstn)
    (ea_go && ea_req.addr <= state_reg.stack_limit_register
      && ea_req.addr >= SPL_SFR_BOUND)
      |=> !trap.trap && !mem.we && !mem.re && $stable(stack_pointer_register))
    else $error("legal stack address was trapped");

  // A trap never comes with a memory access and always names its cause
  a_trap_no_access: assert property (@(posedge clk) disable iff (!rstn)
    trap.trap |-> !mem.we && !mem.re && (trap.over || trap.under))
    else $error("trap came with a memory access or no cause");

  // Pop that lands exactly on the bound is still legal
  a_pop_at_bound: assert property (@(posedge clk) disable iff (!rstn)
    (pop_go && state_reg.stack_pointer_register == 16'(SPL_SFR_BOUND + SPL_WORD_STEP)
      && state_reg.stack_limit_register >= SPL_SFR_BOUND)
      |=> mem.re && !trap.trap && stack_pointer_register == SPL_SFR_BOUND)
    else $error("pop down to the bound was trapped");

  // Push from below the bound traps as underflow and writes nothing
  a_push_under: assert property (@(posedge clk) disable iff (!rstn)
    (push_go && state_reg.stack_pointer_register < SPL_SFR_BOUND)
      |=> trap.trap && trap.under && !mem.we && $stable(stack_pointer_register))
    else $error("push below the bound did not trap");

endmodule

// ### pkg/spl_pkg.sv
// Shared types and constants for the stack pointer limit checker.
// Assumes a 16-bit data space and a 23-bit program counter in the core.
package spl_pkg;

  localparam int SPL_DW = 16;
  localparam int SPL_PCW = 23;
  // Lowest legal stack address; below it lies the special function area
  localparam logic [15:0] SPL_SFR_BOUND = 16'h0800;
  // Stack moves one 16-bit word, two byte addresses, per access
  localparam logic [15:0] SPL_WORD_STEP = 16'h0002;
  // Pointer value after reset; arbitrary plain default at the bottom of the stack
  localparam logic [15:0] SPL_SP_RESET = 16'h0800;
  // Upper byte of a call push is zero-extended
  localparam logic [7:0] SPL_PC_HI_EXT = 8'h00;
  localparam int SPL_PC_LO_W = 16;
  localparam int SPL_PC_HI_MSB = 22;

  typedef enum logic [1:0] {
    SPL_PUSH_DATA = 2'h0,
    SPL_PUSH_CALL = 2'h1,
    SPL_PUSH_EXC  = 2'h2
  } spl_push_kind_t;

  typedef enum logic [1:0] {
    SPL_ST_IDLE  = 2'h1,
    SPL_ST_PC_HI = 2'h2
  } spl_state_t;

  // One stack request from the core, one cycle pulse
  typedef struct packed {
    logic push;
    logic pop;
    spl_push_kind_t kind;
    logic [15:0] data;
    logic [22:0] pc;
    logic [7:0] status_low_byte;
  } spl_stack_req_t;

  // Register writes from the core's write-back path
  typedef struct packed {
    logic sp_we;
    logic [15:0] sp_wdata;
    logic lim_we;
    logic [15:0] lim_wdata;
  } spl_reg_wr_t;

  // Effective address formed with the stack pointer as pointer
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } spl_ea_req_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [15:0] wdata;
  } spl_mem_t;

  typedef struct packed {
    logic trap;
    logic over;
    logic under;
    logic [15:0] addr;
  } spl_trap_t;

  typedef struct packed {
    spl_state_t fsm;
    logic [15:0] stack_pointer_register;
    logic [15:0] stack_limit_register;
    logic [15:0] pc_hi_word;
    spl_mem_t mem;
    spl_trap_t trap;
  } spl_core_state_t;

endpackage

// ### hdl/spl_ea_check.sv
// Bound comparator for one stack effective address.
// Assumes limit bit zero is already cleared by the caller.
`timescale 1ns/1ps
module spl_ea_check
  import spl_pkg::*;
(
  input wire logic [15:0] effective_address,
  input wire logic [15:0] limit,
  input wire logic borrow,
  output logic over,
  output logic under
);

  // Equal to the limit is still legal; only beyond it traps
  always_comb begin
    over = (effective_address > limit) && !borrow;
    under = (effective_address < SPL_SFR_BOUND) || borrow;
  end

endmodule

// ### testbench/spl_core_model.sv
// Stack RAM on the core side, filled by push writes and read by pops.
// Assumes mem.we and mem.re are one-cycle pulses on clk.
`timescale 1ns/1ps
module spl_core_model (
  input wire logic clk,
  input wire spl_pkg::spl_mem_t mem,
  output logic [15:0] rdata
);
  import spl_pkg::*;
  logic [15:0] ram [logic [15:0]];
  initial rdata = 16'h0000;
  // Read data lives one cycle; after that it flips so stale data never matches
  always @(posedge clk) begin
    if (mem.we)
      ram[mem.addr] = mem.wdata;
    if (mem.re && ram.exists(mem.addr))
      rdata <= ram[mem.addr];
    else
      rdata <= ~rdata;
  end
endmodule

// ### testbench/spl_stack_guard_tb.sv
// Self-checking bench for the stack guard against an integer stack model.
// Assumes a 125 MHz clock, inputs driven on the falling edge.
`timescale 1ns/1ps
module spl_stack_guard_tb;
  import spl_pkg::*;
  logic clk, rstn, rdy;
  spl_stack_req_t req;
  spl_reg_wr_t rw;
  spl_ea_req_t ea_r;
  spl_mem_t dmem;
  spl_trap_t trp;
  logic [15:0] sp_o, lim_o, rdata, sp_m, lim_m;
  logic [15:0] stk [$];
  logic [15:0] ea_tab [5] = '{16'h0900, 16'h0902, 16'h07fe, 16'h0800, 16'hfffe};
  logic [31:0] seed, r;
  int miscompares = 0, checks_done = 0, cyc = 0;

  spl_stack_guard dut_u (.clk(clk), .rstn(rstn), .stack_req(req), .reg_wr(rw),
    .ea_req(ea_r), .ready(rdy), .mem(dmem), .trap(trp),
    .stack_pointer_register(sp_o), .stack_limit_register(lim_o));
  spl_core_model core_u (.clk(clk), .mem(dmem), .rdata(rdata));

  always #4 clk = ~clk;
  // Hang guard, well above the roughly one hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (e !== g) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // One cycle of outputs against the model
  task automatic exp_out(input logic we, re, tr, ov, un, input logic [15:0] a, w);
    chk("mem_we", we, dmem.we);
    chk("mem_re", re, dmem.re);
    chk("trap", tr, trp.trap);
    chk("over", ov, trp.over);
    chk("under", un, trp.under);
    if (we || re)
      chk("mem_addr", a, dmem.addr);
    if (we)
      chk("mem_wdata", w, dmem.wdata);
    if (tr)
      chk("trap_addr", a, trp.addr);
    chk("sp", sp_m, sp_o);
  endtask

  task automatic word_exp(input logic [15:0] w);
    if (sp_m > lim_m || sp_m < 16'h0800) begin
      exp_out(1'b0, 1'b0, 1'b1, sp_m > lim_m, sp_m < 16'h0800, sp_m, 16'h0);
    end else begin
      stk.push_back(w);
      sp_m = sp_m + 16'h0002;
      exp_out(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, sp_m - 16'h0002, w);
    end
  endtask

  task automatic push(input spl_push_kind_t k, input logic [15:0] d, input logic [22:0] pc,
    input logic [7:0] sl);
    logic t;
    req.push = 1'b1;
    req.kind = k;
    req.data = d;
    req.pc = pc;
    req.status_low_byte = sl;
    @(negedge clk);
    req.push = 1'b0;
    t = sp_m > lim_m || sp_m < 16'h0800;
    word_exp((k == SPL_PUSH_DATA) ? d : pc[15:0]);
    if (k != SPL_PUSH_DATA && !t) begin
      chk("ready", 1'b0, rdy);
      @(negedge clk);
      word_exp({(k == SPL_PUSH_EXC) ? sl : 8'h00, 1'b0, pc[22:16]});
    end else begin
      // Idle cycle so the next strobe is not raised in the step it was lowered
      @(negedge clk);
    end
  endtask

  task automatic pop();
    logic [15:0] w;
    req.pop = 1'b1;
    @(negedge clk);
    req.pop = 1'b0;
    if (sp_m < 16'h0802) begin
      exp_out(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, sp_m - 16'h0002, 16'h0);
      @(negedge clk);
    end else begin
      sp_m = sp_m - 16'h0002;
      w = stk.pop_back();
      exp_out(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, sp_m, 16'h0);
      @(negedge clk);
      chk("pop_data", w, rdata);
    end
  endtask

  task automatic ea(input logic [15:0] a);
    ea_r.valid = 1'b1;
    ea_r.addr = a;
    @(negedge clk);
    ea_r.valid = 1'b0;
    exp_out(1'b0, 1'b0, a > lim_m || a < 16'h0800, a > lim_m, a < 16'h0800, a, 16'h0);
    chk("ready", 1'b1, rdy);
    @(negedge clk);
  endtask

  task automatic set_reg(input logic lim, input logic [15:0] v);
    rw.lim_we = lim;
    rw.sp_we = !lim;
    rw.lim_wdata = v;
    rw.sp_wdata = v;
    @(negedge clk);
    rw = '0;
    if (lim)
      lim_m = v & 16'hfffe;
    else
      sp_m = v & 16'hfffe;
    chk("limit", lim_m, lim_o);
    chk("sp", sp_m, sp_o);
    // Idle cycle so no stack read follows a limit write
    @(negedge clk);
  endtask

  // Main sequence; the limit write inside reset must survive it
  initial begin
    seed = 32'hd7e53f65;
    clk = 1'b0;
    rstn = 1'b0;
    req = '0;
    ea_r = '0;
    rw = '0;
    rw.lim_we = 1'b1;
    rw.lim_wdata = 16'h0811;
    repeat (4) @(negedge clk);
    rw = '0;
    rstn = 1'b1;
    sp_m = 16'h0800;
    lim_m = 16'h0810;
    chk("limit", lim_m, lim_o);
    exp_out(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
    for (int i = 0; i < 10; i++) begin
      r = $random(seed);
      push(SPL_PUSH_DATA, r[15:0], 23'h0, 8'h00);
    end
    for (int i = 0; i < 10; i++) pop();
    set_reg(1'b1, 16'h0901);
    r = $random(seed);
    push(SPL_PUSH_CALL, 16'h0, r[22:0], r[30:23]);
    r = $random(seed);
    push(SPL_PUSH_EXC, 16'h0, r[22:0], r[31:24]);
    repeat (4) pop();
    set_reg(1'b0, 16'h08ff);
    push(SPL_PUSH_CALL, 16'h0, 23'h7fffff, 8'hff);
    push(SPL_PUSH_DATA, 16'h1234, 23'h0, 8'h00);
    foreach (ea_tab[j]) ea(ea_tab[j]);
    set_reg(1'b0, 16'h0900);
    push(SPL_PUSH_EXC, 16'h0, 23'h2a5a5a, 8'h3c);
    set_reg(1'b0, 16'h0001);
    pop();
    set_reg(1'b0, 16'h07fe);
    push(SPL_PUSH_DATA, 16'h5a5a, 23'h0, 8'h00);
    r = $random(seed);
    ea({4'h0, r[11:1], 1'b0});
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    sp_m = 16'h0800;
    stk.delete();
    chk("limit", lim_m, lim_o);
    exp_out(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
    push(SPL_PUSH_DATA, r[31:16], 23'h0, 8'h00);
    pop();
    finish_test();
  end
endmodule
